// File: logic/hsk_kernel.sv
// hop selection kernel: addition, xor, butterfly permutation, addition, code word bank
//
// What this block does
// - phase picks position in segment; direction inputs pick master or slave hops
// - address ordering inputs fix order; mapping inputs fix frequency mapping
// - hop index comes from add, xor, permute, add, then bank lookup
// - first addition adds constant to phase, modulo 32 or 16
// - low four bits xor address bits 22-19; bit 4 passes unchanged
// - 23-hop variant carries only four bits through the xor
// - seven butterfly stages, fourteen control bits, five or four bits wide
// - control bits 0-8 from nine-bit input, 9-13 from five-bit input xor direction
// - 79-hop control bits swap the listed bit pairs
// - 23-hop control bits swap the listed bit pairs
// - each butterfly is a pair of muxes passing or exchanging two bits
// - second addition adds constant to permuted value, modulo 79 or 23
// - bank holds code words, even channels first then odd channels
// - bit 0 is least significant; high-low ranges include every bit
// - paging and inquiry use address only, phase and direction, mapping offset zero
// - in connection state, phase from clock bits 6-2 or 5-2; otherwise from page_phase
// - both direction inputs come from clock bit 1
// - master clock, native clock and paged clock estimate are kept apart
// - connection state xors address with clock, new segment every 64 or 32 slots
// - 79-hop connection inputs including mapping offset 16 times clock 27-7 mod 79
// - 23-hop connection inputs including mapping offset 8 times clock 27-6 mod 23
`timescale 1ns/10ps
module hsk_kernel
    import hsk_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // mode selection
    input wire logic hop79,
    input wire logic connection,
    input wire logic use_estimate,
    input wire logic [4:0] page_phase,
    // clocks and address from the link controller
    input wire logic [HSK_CLK_W-1:0] master_clock,
    input wire logic [HSK_CLK_W-1:0] native_clock,
    input wire logic [HSK_CLK_W-1:0] paged_clock_estimate,
    input wire logic [HSK_ADDR_W-1:0] device_address,
    // code word bank load
    input wire logic bank_load,
    input wire logic [HSK_IDX_W-1:0] bank_channel,
    input wire logic [HSK_CW_W-1:0] bank_word,
    // result
    output logic hop_valid,
    output logic [HSK_IDX_W-1:0] hop_index,
    output logic [HSK_IDX_W-1:0] hop_channel,
    output logic [HSK_CW_W-1:0] hop_code_word
);

    hsk_state_t s_q;
    hsk_state_t s_d;
    logic [HSK_CW_W-1:0] bank [HSK_BANK_MAX];
    logic [HSK_IDX_W-1:0] load_pos;

    // one butterfly stage set, bits above width stay zero
    function automatic logic [4:0] hsk_permute(input logic [4:0] z, input logic [13:0] p,
                                               input logic sys79);
        logic [4:0] v;
        logic [2:0] lo;
        logic [2:0] hi;
        logic t;
        v = z;
        for (int i = 0; i < HSK_STAGES; i++) begin
            lo = sys79 ? HSK_LO79[i] : HSK_LO23[i];
            hi = sys79 ? HSK_HI79[i] : HSK_HI23[i];
            t = v[lo];
            v[lo] = p[i] ? v[hi] : v[lo];
            v[hi] = p[i] ? t : v[hi];
        end
        return v;
    endfunction : hsk_permute

    // bank position of a channel: even channels in the first half
    always_comb begin
        load_pos = {1'b0, bank_channel[HSK_IDX_W-1:1]};
        if (bank_channel[0]) begin
            load_pos = (hop79 ? HSK_HALF79 : HSK_HALF23)
                + {1'b0, bank_channel[HSK_IDX_W-1:1]};
        end
    end

    always_ff @(posedge clk) begin
        if (bank_load && (bank_channel < (hop79 ? 7'h4f : 7'h17))) begin
            bank[load_pos] <= bank_word;
        end
    end

    logic [HSK_CLK_W-1:0] ck;
    logic [4:0] x_in;
    logic y1;
    logic [5:0] y2;
    logic [4:0] a_in;
    logic [3:0] b_in;
    logic [4:0] c_in;
    logic [8:0] d_in;
    logic [6:0] e_in;
    logic [HSK_IDX_W-1:0] f_in;
    logic [24:0] f_prod;
    logic [4:0] z1;
    logic [4:0] z2;
    logic [13:0] ctrl;
    logic [4:0] perm;
    logic [HSK_SUM_W-1:0] sum2;
    logic [HSK_SUM_W-1:0] idx_wide;
    logic [HSK_IDX_W-1:0] idx;
    logic [HSK_IDX_W-1:0] half;

    always_comb begin
        s_d = s_q;
        s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
        // clock source per state
        if (connection) begin
            ck = master_clock;
        end else if (use_estimate) begin
            ck = paged_clock_estimate;
        end else begin
            ck = native_clock;
        end
        // phase and direction
        if (connection) begin
            x_in = hop79 ? ck[6:2] : {1'b0, ck[5:2]};
        end else begin
            x_in = hop79 ? page_phase : {1'b0, page_phase[3:0]};
        end
        y1 = ck[1];
        y2 = y1 ? (hop79 ? HSK_DIR79 : HSK_DIR23) : 6'h00;
        // address inputs, clock mixed in only in connection state
        a_in = device_address[27:23];
        b_in = device_address[22:19];
        c_in = {device_address[8], device_address[6], device_address[4],
                device_address[2], device_address[0]};
        d_in = device_address[18:10];
        e_in = {device_address[13], device_address[11], device_address[9], device_address[7],
                device_address[5], device_address[3], device_address[1]};
        f_prod = 25'h0;
        f_in = 7'h00;
        if (connection) begin
            a_in = a_in ^ ck[25:21];
            c_in = c_in ^ ck[20:16];
            d_in = d_in ^ ck[15:7];
            if (hop79) begin
                f_prod = {ck[27:7], 4'h0};
                f_in = 7'(f_prod % HSK_MOD79);
            end else begin
                f_prod = {ck[27:6], 3'h0};
                f_in = 7'(f_prod % HSK_MOD23);
            end
        end
        // first addition wraps at segment length
        z1 = x_in + a_in;
        if (!hop79) begin
            z1[4] = 1'b0;
        end
        // xor of the four low bits, bit 4 straight through
        z2 = {z1[4], z1[3:0] ^ b_in};
        ctrl = {c_in ^ {5{y1}}, d_in};
        perm = hsk_permute(z2, ctrl, hop79);
        // second addition wraps at band size
        sum2 = 9'(perm) + 9'(e_in) + 9'(f_in) + 9'(y2);
        idx_wide = sum2 % (hop79 ? HSK_BAND79 : HSK_BAND23);
        idx = idx_wide[HSK_IDX_W-1:0];
        half = hop79 ? HSK_HALF79 : HSK_HALF23;
        s_d.hop_index = idx;
        s_d.channel = (idx < half) ? {idx[5:0], 1'b0}
            : {7'(idx - half)} * 7'h02 + 7'h01;
        s_d.code_word = bank[idx];
        s_d.valid = 1'b1;
        if (!s_q.rst_sync[1]) begin
            s_d.valid = 1'b0;
            s_d.hop_index = 7'h00;
            s_d.channel = 7'h00;
            s_d.code_word = 10'h000;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign hop_valid = s_q.valid;
    assign hop_index = s_q.hop_index;
    assign hop_channel = s_q.channel;
    assign hop_code_word = s_q.code_word;

endmodule : hsk_kernel

// File: logic/hsk_pkg.sv
// constants for the hop selection kernel
package hsk_pkg;
    localparam int HSK_CLK_W = 28;
    localparam int HSK_ADDR_W = 28;
    localparam int HSK_IDX_W = 7;
    localparam int HSK_SUM_W = 9;
    localparam int HSK_CW_W = 10;
    localparam int HSK_STAGES = 14;
    localparam int HSK_BANK_MAX = 79;
    // segment and band sizes per hop system
    localparam logic [HSK_SUM_W-1:0] HSK_BAND79 = 9'h04f;
    localparam logic [HSK_SUM_W-1:0] HSK_BAND23 = 9'h017;
    localparam logic [HSK_IDX_W-1:0] HSK_HALF79 = 7'h28;
    localparam logic [HSK_IDX_W-1:0] HSK_HALF23 = 7'h0c;
    localparam logic [5:0] HSK_DIR79 = 6'h20;
    localparam logic [5:0] HSK_DIR23 = 6'h10;
    localparam logic [24:0] HSK_MOD79 = 25'h000004f;
    localparam logic [24:0] HSK_MOD23 = 25'h0000017;
    // butterfly pairs, entry i is steered by control bit i
    localparam logic [2:0] HSK_LO79 [HSK_STAGES] =
        '{3'h0, 3'h2, 3'h1, 3'h3, 3'h0, 3'h1, 3'h0, 3'h3, 3'h1, 3'h0, 3'h2, 3'h1, 3'h0, 3'h1};
    localparam logic [2:0] HSK_HI79 [HSK_STAGES] =
        '{3'h1, 3'h3, 3'h2, 3'h4, 3'h4, 3'h3, 3'h2, 3'h4, 3'h4, 3'h3, 3'h4, 3'h3, 3'h3, 3'h2};
    localparam logic [2:0] HSK_LO23 [HSK_STAGES] =
        '{3'h0, 3'h2, 3'h0, 3'h1, 3'h0, 3'h1, 3'h0, 3'h2, 3'h0, 3'h1, 3'h0, 3'h1, 3'h0, 3'h2};
    localparam logic [2:0] HSK_HI23 [HSK_STAGES] =
        '{3'h1, 3'h3, 3'h3, 3'h2, 3'h2, 3'h3, 3'h1, 3'h3, 3'h2, 3'h3, 3'h3, 3'h2, 3'h1, 3'h3};

    typedef struct packed {
        logic [1:0] rst_sync;
        logic valid;
        logic [HSK_IDX_W-1:0] hop_index;
        logic [HSK_IDX_W-1:0] channel;
        logic [HSK_CW_W-1:0] code_word;
    } hsk_state_t;
endpackage : hsk_pkg

// File: tb/hsk_link_model.sv
// link controller model: the three clocks seen by the kernel
`timescale 1ns/10ps
module hsk_link_model
    import hsk_pkg::*;
(
    // clock, clock step, clock outputs
    input wire logic clk,
    input wire logic [HSK_CLK_W-1:0] step,
    output logic [HSK_CLK_W-1:0] master_clock,
    output logic [HSK_CLK_W-1:0] native_clock,
    output logic [HSK_CLK_W-1:0] paged_clock_estimate
);
    initial native_clock = 28'h0;
    always @(negedge clk) native_clock <= native_clock + step;
    assign master_clock = native_clock + 28'h5a3c15e;
    assign paged_clock_estimate = native_clock ^ 28'h0000002;
endmodule : hsk_link_model

// File: tb/hsk_kernel_monitor.sv
// port checker for the hop selection kernel
`timescale 1ns/10ps
module hsk_kernel_monitor
    import hsk_pkg::*;
(
    // watched ports
    input wire logic clk,
    input wire logic nrst,
    input wire logic hop79,
    input wire logic bank_load,
    input wire logic hop_valid,
    input wire logic [HSK_IDX_W-1:0] hop_index,
    input wire logic [HSK_IDX_W-1:0] hop_channel,
    input wire logic [HSK_CW_W-1:0] hop_code_word
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_rel; $rose(nrst) |-> !hop_valid [*3] ##1 hop_valid; endproperty
    a_rel: assert property (p_rel) else $error("valid timing after reset");
    property p_keep; hop_valid |=> hop_valid; endproperty
    a_keep: assert property (p_keep) else $error("valid dropped");
    property p_zero; !hop_valid |-> hop_index == 7'h0 && hop_channel == 7'h0
        && hop_code_word == 10'h0; endproperty
    a_zero: assert property (p_zero) else $error("output before valid");
    property p_rng; hop_valid |-> hop_index < ($past(hop79) ? 7'h4f : 7'h17); endproperty
    a_rng: assert property (p_rng) else $error("index out of band");
    property p_c79; hop_valid && $past(hop79) |-> hop_channel ==
        (hop_index < 7'h28 ? 7'(hop_index * 7'h2) : 7'(hop_index * 7'h2 - 7'h4f)); endproperty
    a_c79: assert property (p_c79) else $error("channel order, 79 hops");
    property p_c23; hop_valid && !$past(hop79) |-> hop_channel ==
        (hop_index < 7'h0c ? 7'(hop_index * 7'h2) : 7'(hop_index * 7'h2 - 7'h17)); endproperty
    a_c23: assert property (p_c23) else $error("channel order, 23 hops");
    property p_odd; hop_valid && hop_channel[0] |->
        hop_index >= ($past(hop79) ? 7'h28 : 7'h0c); endproperty
    a_odd: assert property (p_odd) else $error("odd channel in even half");
    property p_cw; hop_valid && $past(hop_valid) && $stable(hop_index) && !$past(bank_load)
        |-> $stable(hop_code_word); endproperty
    a_cw: assert property (p_cw) else $error("code word moved");
    c_79: cover property (hop_valid && hop79);
    c_23: cover property (hop_valid && !hop79);
    c_load: cover property (bank_load && hop_valid);
endmodule : hsk_kernel_monitor
bind hsk_kernel hsk_kernel_monitor i_hsk_kernel_monitor (.clk, .nrst, .hop79, .bank_load,
    .hop_valid, .hop_index, .hop_channel, .hop_code_word);

// File: tb/tb_top.sv
// self-checking bench for the hop selection kernel
`timescale 1ns/10ps
module tb_top
    import hsk_pkg::*;
;
    localparam logic [111:0] PAIRS79 = 112'h0123123404130234140324130312;
    localparam logic [111:0] PAIRS23 = 112'h0123031202130123021303120123;
    logic clk = 1'b0, nrst = 1'b0, hop79 = 1'b1, connection = 1'b1, use_estimate = 1'b0;
    logic bank_load = 1'b0, hop_valid;
    logic [4:0] page_phase = 5'h0;
    logic [27:0] step = 28'h0, device_address = 28'h0, master_clock, native_clock;
    logic [27:0] paged_clock_estimate;
    logic [6:0] bank_channel = 7'h0, hop_index, hop_channel;
    logic [9:0] bank_word = 10'h0, hop_code_word;
    int bad_count = 0, num_checks = 0;
    hsk_kernel i_hsk_kernel (.clk(clk), .nrst(nrst), .hop79(hop79), .connection(connection),
        .use_estimate(use_estimate), .page_phase(page_phase), .master_clock(master_clock),
        .native_clock(native_clock), .paged_clock_estimate(paged_clock_estimate),
        .device_address(device_address), .bank_load(bank_load), .bank_channel(bank_channel),
        .bank_word(bank_word), .hop_valid(hop_valid), .hop_index(hop_index),
        .hop_channel(hop_channel), .hop_code_word(hop_code_word));
    hsk_link_model i_hsk_link_model (.clk(clk), .step(step), .master_clock(master_clock),
        .native_clock(native_clock), .paged_clock_estimate(paged_clock_estimate));
    initial forever #25 clk = ~clk;
    task automatic chk(input logic ok);
        num_checks++;
        if (!ok) begin
            bad_count++;
            $display("[FAIL] %0t mismatch at check %0d", $time, num_checks);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic reset_release();
        repeat (12) @(negedge clk);
        nrst <= 1'b1;
        repeat (2) @(negedge clk);
        chk(hop_valid === 1'b0 && hop_index === 7'h0);
        @(negedge clk);
        chk(hop_valid === 1'b1);
    endtask : reset_release
    task automatic load_bank();
        bank_load <= 1'b1;
        // every channel up to 79 is offered: those beyond the band must be ignored
        for (int c = 0; c <= 79; c++) begin
            bank_channel <= 7'(c);
            bank_word <= {3'h5, 7'(c)};
            page_phase <= 5'(c);
            @(negedge clk);
        end
        bank_load <= 1'b0;
    endtask : load_bank
    task automatic run_hops(input int n);
        logic [27:0] k, a;
        logic [13:0] p;
        logic [7:0] b;
        logic [6:0] h;
        logic [4:0] z;
        int s, m;
        repeat (n) begin
            page_phase <= page_phase + 5'h7;
            device_address <= device_address * 28'h5 + 28'h3c6ef35;
            #1;
            a = device_address;
            k = connection ? master_clock
                : use_estimate ? paged_clock_estimate : native_clock;
            m = hop79 ? 79 : 23;
            z = (connection ? k[6:2] : page_phase)
                + (a[27:23] ^ (connection ? k[25:21] : 5'h0));
            z[4] = z[4] & hop79;
            z[3:0] = z[3:0] ^ a[22:19];
            p = {{a[8], a[6], a[4], a[2], a[0]} ^ {5{k[1]}}, a[18:10]};
            if (connection) p = p ^ {k[20:16], k[15:7]};
            for (int i = 0; i < 14; i++) begin
                b = 8'((hop79 ? PAIRS79 : PAIRS23) >> (104 - 8 * i));
                if (p[i]) {z[b[7:4]], z[b[3:0]]} = {z[b[3:0]], z[b[7:4]]};
            end
            s = z + {a[13], a[11], a[9], a[7], a[5], a[3], a[1]}
                + (hop79 ? 32 : 16) * k[1];
            if (connection) s += hop79 ? 16 * int'(k[27:7]) % 79
                : 8 * int'(k[27:6]) % 23;
            s = s % m;
            h = 7'(s < (m + 1) / 2 ? 2 * s : 2 * s - m);
            @(negedge clk);
            chk(hop_valid === 1'b1 && hop_index === 7'(s));
            chk(hop_channel === h && hop_code_word === {3'h5, h});
        end
    endtask : run_hops
    initial begin
        reset_release();
        load_bank();
        repeat (4) @(negedge clk);
        step <= 28'h01b5d2f;
        run_hops(60);
        connection <= 1'b0;
        run_hops(30);
        use_estimate <= 1'b1;
        run_hops(30);
        {hop79, connection, step} <= {2'h1, 28'h0};
        load_bank();
        step <= 28'h0a3f1c7;
        run_hops(60);
        connection <= 1'b0;
        run_hops(30);
        give_verdict();
    end
    initial begin
        #50000;
        bad_count++;
        give_verdict();
    end
endmodule : tb_top
